/* hw/mrpu_unit.sv */
// Memory region protection unit: region lookup, attributes, faults, APB registers
// Operation
// - Shareable regions are flagged so the memory system keeps all masters coherent
// - Strongly-ordered regions always report shareable regardless of the S bit
// - Fetches from execute-never regions are blocked; fault only when executed
// - Device and strongly-ordered accesses are flagged as strictly ordered
// - Regions of 256 bytes or more split into eight equal subregions
// - Set disable-mask bit disables subregion; bit zero is lowest addressed
// - Disabled subregion falls to other enabled region, else protection fault
// - Unaligned register accesses are refused and change nothing
// - Type extension b000, C=1, B=0 gives normal write-through; S picks shareability
// - Type extension b000 with C=1,B=1 gives write-back; C=0,B=1 gives device
`timescale 1ns/10ps
`default_nettype none

module mrpu_unit (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    // APB register port
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Core data access
    input  wire mrpu_pkg::mrpu_access_type dataReq,
    output mrpu_pkg::mrpu_attr_type     dataAttr,
    // Core instruction fetch and execute
    input  wire mrpu_pkg::mrpu_access_type fetchReq,
    output mrpu_pkg::mrpu_attr_type     fetchAttr,
    output logic                        fetchBlocked,
    input  wire mrpu_pkg::mrpu_access_type execReq,
    output logic                        execFault,
    // Interrupt
    output logic                        irq
);
    import mrpu_pkg::*;

    // ==========================================================
    // Region storage and control registers
    // Base keeps bits 31:5 only, so a region smaller than 32 bytes starts on a 32-byte boundary
    logic [26:0]        baseQ [REGION_COUNT];
    logic [31:0]        attrQ [REGION_COUNT];
    logic               enableQ;
    logic [STAT_W-1:0]  statusQ;
    logic [STAT_W-1:0]  statusD;
    logic [STAT_W-1:0]  maskQ;
    logic [31:0]        faultAddrQ;

    // ==========================================================
    // Lookup helpers
    function automatic logic regionHit(input logic [26:0] base, input logic [31:0] attr,
                                       input logic [31:0] a);
        logic [5:0]  sizeLog2;
        logic [32:0] lowMask;
        logic [2:0]  subIdx;
        logic        tagMatch;
        logic        subOff;
        sizeLog2 = {1'b0, attr[ATTR_SIZE_LSB +: 5]} + 6'd1;
        lowMask = (33'd1 << sizeLog2) - 33'd1;
        tagMatch = ((a ^ {base, 5'h00}) & ~lowMask[31:0]) == 32'h0000_0000;
        // Subregion index is the top three offset bits inside the region
        subIdx = 3'(a >> (sizeLog2 - 6'd3));
        subOff = (sizeLog2 >= 6'(MIN_SUB_LOG2)) && attr[ATTR_SUBDIS_LSB + subIdx];
        regionHit = attr[ATTR_EN_BIT] && tagMatch && !subOff;
    endfunction

    function automatic mrpu_attr_type decodeAttr(input logic [31:0] attr);
        mrpu_attr_type r;
        logic [2:0]    typeExt;
        logic          c;
        logic          b;
        r = '0;
        typeExt = attr[ATTR_TYPEX_LSB +: 3];
        c = attr[ATTR_C_BIT];
        b = attr[ATTR_B_BIT];
        r.hit = 1'b1;
        r.execNever = attr[ATTR_EXEC_NEVER_BIT];
        r.shareable = attr[ATTR_S_BIT];
        r.memType = MEM_NORMAL;
        // Basic type extension: C and B pick the memory type directly
        if (typeExt == TYPEX_BASIC) begin
            case ({c, b})
                2'b00: begin
                    r.memType = MEM_STRONG;
                end
                2'b01: begin
                    r.memType = MEM_DEVICE;
                    r.bufferable = 1'b1;
                end
                2'b10: begin
                    r.cacheable = 1'b1;
                    r.bufferable = 1'b1;
                end
                default: begin
                    r.cacheable = 1'b1;
                    r.writeBack = 1'b1;
                    r.bufferable = 1'b1;
                end
            endcase
        end else begin
            // Other type extension codes give plain normal memory; code 001 is not cacheable
            // Finer cache policies are not modelled: write-back simply follows B
            r.cacheable = (typeExt != TYPEX_NONCACHE);
            r.writeBack = r.cacheable && b;
            r.bufferable = 1'b1;
        end
        if (r.memType == MEM_STRONG) begin
            r.shareable = 1'b1;
            r.bufferable = 1'b0;  // Writes here must not be posted
        end
        r.ordered = (r.memType != MEM_NORMAL);
        decodeAttr = r;
    endfunction

    // ==========================================================
    // Per-region match for each of the three lookup ports
    logic [REGION_COUNT-1:0] hitData;
    logic [REGION_COUNT-1:0] hitFetch;
    logic [REGION_COUNT-1:0] hitExec;

    // Three comparator sets so data, fetch and execute never wait on each other
    for (genvar g = 0; g < REGION_COUNT; g++) begin : gRegion
        assign hitData[g] = regionHit(baseQ[g], attrQ[g], dataReq.addr);
        assign hitFetch[g] = regionHit(baseQ[g], attrQ[g], fetchReq.addr);
        assign hitExec[g] = regionHit(baseQ[g], attrQ[g], execReq.addr);
    end

    function automatic mrpu_attr_type pickRegion(input logic [REGION_COUNT-1:0] hits,
                                                 input logic unitOn);
        mrpu_attr_type r;
        r = '0;
        r.memType = MEM_NORMAL;
        r.cacheable = 1'b1;
        r.bufferable = 1'b1;
        if (!unitOn) begin
            r.hit = 1'b1;
        end else begin
            r.fault = 1'b1;
            // Later matches overwrite earlier ones, so the highest number wins
            for (int i = 0; i < REGION_COUNT; i++) begin
                if (hits[i]) begin
                    r = decodeAttr(attrQ[i]);
                end
            end
        end
        pickRegion = r;
    endfunction

    mrpu_attr_type dataLook;
    mrpu_attr_type fetchLook;
    mrpu_attr_type execLook;
    logic          dataFaultEv;
    logic          fetchBlockEv;
    logic          execFaultEv;

    // Processes, not assigns: the lookup reads the region array inside the function
    always_comb begin
        dataLook = pickRegion(hitData, enableQ);
    end
    always_comb begin
        fetchLook = pickRegion(hitFetch, enableQ);
    end
    always_comb begin
        execLook = pickRegion(hitExec, enableQ);
    end
    assign dataFaultEv = dataReq.valid && dataLook.fault;
    // A speculative fetch is only stopped; the fault waits for execution
    assign fetchBlockEv = fetchReq.valid && (fetchLook.fault || fetchLook.execNever);
    assign execFaultEv = execReq.valid && (execLook.fault || execLook.execNever);

    // ==========================================================
    // Registered lookup answers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dataAttr <= '0;
            fetchAttr <= '0;
        end else begin
            dataAttr <= dataReq.valid ? dataLook : '0;
            fetchAttr <= fetchReq.valid ? fetchLook : '0;
        end
    end

    // Fault outputs are high one cycle after each faulting request cycle; the status register keeps the sticky copy
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fetchBlocked <= 1'b0;
            execFault <= 1'b0;
        end else begin
            fetchBlocked <= fetchBlockEv;
            execFault <= execFaultEv;
        end
    end

    // ==========================================================
    // APB decode
    logic        access;
    logic        aligned;
    logic        inRegion;
    logic        isAttr;
    logic        fullWord;
    logic        mapped;
    logic        accepted;
    logic [2:0]  regIdx;
    logic [31:0] byteMask;

    assign access = psel && penable;
    assign aligned = (paddr[1:0] == 2'b00);
    assign inRegion = (paddr >= OFS_REGION_BASE) && (paddr < OFS_REGION_END);
    assign regIdx = paddr[5:3];
    assign isAttr = inRegion && paddr[2];
    assign fullWord = (pstrb == 4'hF) || !pwrite;
    assign mapped = inRegion || (paddr == OFS_CTRL) || (paddr == OFS_STATUS)
                  || (paddr == OFS_MASK) || (paddr == OFS_FAULT_ADDR);
    // Only the attribute register takes partial strobes; unaligned never accepted
    assign accepted = aligned && mapped && (fullWord || isAttr);
    // Zero wait states: every register answers in the access phase
    assign pready = 1'b1;
    assign pslverr = access && !accepted;

    for (genvar g = 0; g < 4; g++) begin : gLane
        assign byteMask[8*g +: 8] = {8{pstrb[g]}};
    end

    logic writeHit;
    assign writeHit = access && pwrite && accepted;

    // ==========================================================
    // Control registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            enableQ <= 1'b0;
            maskQ <= MASK_RESET;
        end else if (writeHit) begin
            if (paddr == OFS_CTRL) begin
                enableQ <= pwdata[0];
            end
            if (paddr == OFS_MASK) begin
                maskQ <= pwdata[STAT_W-1:0];
            end
        end
    end

    // Region registers; attribute register merges byte lanes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < REGION_COUNT; i++) begin
                baseQ[i] <= BASE_RESET[31:5];
                attrQ[i] <= ATTR_RESET;
            end
        end else if (writeHit && inRegion) begin
            if (isAttr) begin
                attrQ[regIdx] <= ((attrQ[regIdx] & ~byteMask)
                                 | (pwdata & byteMask)) & ATTR_WMASK;
            end else begin
                baseQ[regIdx] <= pwdata[31:5];
            end
        end
    end

    // ==========================================================
    // Sticky status, write one to clear; a new event wins over the clear
    always_comb begin
        statusD = statusQ;
        if (writeHit && (paddr == OFS_STATUS)) begin
            statusD = statusQ & ~pwdata[STAT_W-1:0];
        end
        statusD[STAT_DATA_FAULT] = statusD[STAT_DATA_FAULT] | dataFaultEv;
        statusD[STAT_FETCH_BLOCK] = statusD[STAT_FETCH_BLOCK] | fetchBlockEv;
        statusD[STAT_EXEC_FAULT] = statusD[STAT_EXEC_FAULT] | execFaultEv;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            statusQ <= '0;
        end else begin
            statusQ <= statusD;
        end
    end

    // Fault address keeps the most recent faulting data or executed address
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            faultAddrQ <= 32'h0000_0000;
        end else if (execFaultEv) begin
            faultAddrQ <= execReq.addr;
        end else if (dataFaultEv) begin
            faultAddrQ <= dataReq.addr;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(statusD & maskQ);
        end
    end

    // ==========================================================
    // Read mux
    // Zero outside an accepted read, so a refused access returns nothing
    always_comb begin
        prdata = 32'h0000_0000;
        if (access && !pwrite && accepted) begin
            if (inRegion) begin
                prdata = isAttr ? attrQ[regIdx] : {baseQ[regIdx], 5'h00};
            end else begin
                case (paddr)
                    OFS_CTRL: begin
                        prdata = {31'h0000_0000, enableQ};
                    end
                    OFS_STATUS: begin
                        prdata = {29'h0000_0000, statusQ};
                    end
                    OFS_MASK: begin
                        prdata = {29'h0000_0000, maskQ};
                    end
                    OFS_FAULT_ADDR: begin
                        prdata = faultAddrQ;
                    end
                    default: begin
                        prdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* hw/mrpu_pkg.sv */
// Shared constants and carrier types of the memory region protection unit
package mrpu_pkg;

    // ==========================================================
    // Geometry
    localparam int unsigned REGION_COUNT = 8;
    localparam int unsigned SUBREGION_COUNT = 8;
    localparam int unsigned MIN_SUB_LOG2 = 8;   // 256-byte regions and up have subregions
    localparam int unsigned APB_ADDR_W = 12;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_MASK = 12'h008;
    localparam logic [11:0] OFS_FAULT_ADDR = 12'h00C;
    localparam logic [11:0] OFS_REGION_BASE = 12'h040;  // Region n base at +8n
    localparam logic [11:0] OFS_REGION_ATTR = 12'h044;  // Region n attribute/size at +8n
    localparam logic [11:0] OFS_REGION_END = 12'h080;

    // ==========================================================
    // Attribute/size register fields
    localparam int unsigned ATTR_EN_BIT = 0;
    localparam int unsigned ATTR_SIZE_LSB = 1;
    localparam int unsigned ATTR_SUBDIS_LSB = 8;
    localparam int unsigned ATTR_B_BIT = 16;
    localparam int unsigned ATTR_C_BIT = 17;
    localparam int unsigned ATTR_S_BIT = 18;
    localparam int unsigned ATTR_TYPEX_LSB = 19;
    localparam int unsigned ATTR_EXEC_NEVER_BIT = 28;
    localparam logic [31:0] ATTR_WMASK = 32'h1000_0000 | 32'h003F_FF3F;
    localparam logic [31:0] ATTR_RESET = 32'h0000_0000;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;

    // Status / mask bits
    localparam int unsigned STAT_DATA_FAULT = 0;
    localparam int unsigned STAT_FETCH_BLOCK = 1;
    localparam int unsigned STAT_EXEC_FAULT = 2;
    localparam int unsigned STAT_W = 3;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [2:0] TYPEX_BASIC = 3'h0;
    localparam logic [2:0] TYPEX_NONCACHE = 3'h1;

    // ==========================================================
    // Memory types
    typedef enum logic [1:0] {
        MEM_STRONG = 2'h0,
        MEM_DEVICE = 2'h1,
        MEM_NORMAL = 2'h2
    } mrpu_mem_type;

    typedef struct packed {
        logic         hit;        // Some enabled region matched, or the unit is disabled
        logic         fault;      // Protection fault for this access
        mrpu_mem_type memType;
        logic         shareable;
        logic         cacheable;
        logic         writeBack;  // Write-back write-allocate, else write-through
        logic         bufferable; // Writes may be posted
        logic         ordered;    // Must keep order against other ordered accesses
        logic         execNever;
    } mrpu_attr_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
    } mrpu_access_type;

endpackage

/* sim/mrpu_unit_props.sv */
// Concurrent checks on the protection unit ports
`timescale 1ns/10ps
`default_nettype none
module mrpu_unit_props (
    // Clock and reset
    input wire logic                      ref_clk,
    input wire logic                      resetn,
    // APB
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic [11:0]               paddr,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    // Lookups
    input wire mrpu_pkg::mrpu_access_type dataReq,
    input wire mrpu_pkg::mrpu_attr_type   dataAttr,
    input wire mrpu_pkg::mrpu_access_type fetchReq,
    input wire mrpu_pkg::mrpu_attr_type   fetchAttr,
    input wire logic                      fetchBlocked,
    input wire mrpu_pkg::mrpu_access_type execReq,
    input wire logic                      execFault
);
    import mrpu_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // ======
    // Fetch steps
    sequence s_noexec_fetch;
        fetchReq.valid ##1 fetchAttr.execNever;
    endsequence
    sequence s_fetch_only;
        fetchReq.valid && !execReq.valid;
    endsequence
    // ======
    // Properties
    a_misalign_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0000_0000) else $error("misaligned access not refused");
    a_zero_wait: assert property (psel && !penable |=> pready) else $error("access phase stalled");
    a_strong_share: assert property (dataAttr.hit && dataAttr.memType == MEM_STRONG |-> dataAttr.shareable && !dataAttr.bufferable) else $error("strong region not shareable");
    a_order_kind: assert property (dataAttr.hit |-> dataAttr.ordered == (dataAttr.memType != MEM_NORMAL)) else $error("ordering flag wrong");
    a_device_post: assert property (dataAttr.hit && dataAttr.memType == MEM_DEVICE |-> dataAttr.bufferable) else $error("device writes not postable");
    a_fault_miss: assert property (dataAttr.fault |-> !dataAttr.hit) else $error("fault with a hit");
    a_data_idle: assert property (!dataReq.valid |=> dataAttr == '0) else $error("attribute without access");
    a_noexec_block: assert property (s_noexec_fetch |-> fetchBlocked) else $error("fetch from no-execute area not blocked");
    a_block_cause: assert property (fetchBlocked |-> $past(fetchReq.valid) && (fetchAttr.execNever || fetchAttr.fault)) else $error("fetch block without cause");
    a_exec_only: assert property (s_fetch_only |=> !execFault) else $error("fault raised on fetch alone");
    a_exec_cause: assert property (execFault |-> $past(execReq.valid)) else $error("exec fault without execution");
endmodule
bind mrpu_unit mrpu_unit_props u_props (.ref_clk, .resetn, .psel, .penable, .paddr, .prdata,
    .pready, .pslverr, .dataReq, .dataAttr, .fetchReq, .fetchAttr, .fetchBlocked, .execReq,
    .execFault);
`default_nettype wire

/* sim/mrpu_core_model.sv */
// Core-side model issuing data, fetch and execute lookups
`timescale 1ns/10ps
`default_nettype none
module mrpu_core_model (
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 resetn,
    // Bench commands
    input wire logic                 dataGo,
    input wire logic                 fetchGo,
    input wire logic                 execGo,
    input wire logic                 dataWr,
    input wire logic [31:0]          dAddr,
    input wire logic [31:0]          fAddr,
    // Lookup requests
    output mrpu_pkg::mrpu_access_type dataReq,
    output mrpu_pkg::mrpu_access_type fetchReq,
    output mrpu_pkg::mrpu_access_type execReq
);
    import mrpu_pkg::*;
    logic [31:0] lastFetch_q;
    // Execution only ever follows a fetch of the same address
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lastFetch_q <= 32'h0000_0000;
        end else if (fetchGo) begin
            lastFetch_q <= fAddr;
        end
    end
    // Sole master, so non-shareable regions need no coherency work; idle addresses scrambled
    assign dataReq = '{valid: dataGo, write: dataWr, addr: dataGo ? dAddr : ~dAddr};
    assign fetchReq = '{valid: fetchGo, write: 1'b0, addr: fetchGo ? fAddr : ~fAddr};
    assign execReq = '{valid: execGo, write: 1'b0, addr: lastFetch_q};
endmodule
`default_nettype wire

/* sim/test_memory_region_protection_unit.sv */
// Self-checking bench of the protection unit against a behavioural region model
`timescale 1ns/10ps
`default_nettype none
module test_memory_region_protection_unit;
    import mrpu_pkg::*;
    logic            ref_clk = 0;
    logic            resetn = 0;
    logic            psel = 0;
    logic            penable = 0;
    logic            pwrite = 0;
    logic [11:0]     paddr = 0;
    logic [31:0]     pwdata = 0;
    logic [3:0]      pstrb = 0;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    mrpu_access_type dataReq;
    mrpu_access_type fetchReq;
    mrpu_access_type execReq;
    mrpu_attr_type   dataAttr;
    mrpu_attr_type   fetchAttr;
    logic            fetchBlocked;
    logic            execFault;
    logic            irq;
    logic            dataGo = 0;
    logic            fetchGo = 0;
    logic            execGo = 0;
    logic            dataWr = 0;
    logic [31:0]     dAddr = 0;
    logic [31:0]     fAddr = 0;
    logic [31:0]     mBase [8];
    logic [31:0]     mAttr [8];
    logic            mOn = 0;
    logic            sawD = 0;
    logic            sawF = 0;
    logic [31:0]     rd;
    logic            er;
    int              mismatches = 0;
    int              cmp_count = 0;
    int              seed = 32'heb6f;

    mrpu_unit dut (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .dataReq, .dataAttr, .fetchReq, .fetchAttr, .fetchBlocked, .execReq,
        .execFault, .irq);
    mrpu_core_model core (.ref_clk, .resetn, .dataGo, .fetchGo, .execGo, .dataWr, .dAddr, .fAddr,
        .dataReq, .fetchReq, .execReq);

    initial forever #5 ref_clk = ~ref_clk;
    initial begin
        #50000;
        mismatches++;
        end_of_test();
    end

    // ======
    // Shared tasks
    task automatic end_of_test();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // Single transfers at any address and strobes; only the watchdog ends the wait on pready
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d; pstrb <= s;
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(a, 1'b0, 32'h0000_0000, 4'hF);
        chk("prdata", e, rd);
        chk("pslverr", ee, er);
    endtask
    task automatic cfg(input int n, input logic [31:0] b, input logic [31:0] t);
        apb(OFS_REGION_BASE + 12'(8 * n), 1'b1, b, 4'hF);
        apb(OFS_REGION_ATTR + 12'(8 * n), 1'b1, t, 4'hF);
        mBase[n] = b;
        mAttr[n] = t & ATTR_WMASK;
    endtask
    function automatic mrpu_attr_type model(input logic [31:0] a, input logic v);
        mrpu_attr_type r;
        int s;
        int h;
        logic [31:0] t;
        r = '0;
        h = -1;
        if (!v) return r;
        if (!mOn) begin
            r.hit = 1; r.memType = MEM_NORMAL; r.cacheable = 1; r.bufferable = 1;
            return r;
        end
        for (int n = 0; n < 8; n++) begin
            s = int'(mAttr[n][5:1]) + 1;
            if (mAttr[n][0] && (a >> s) == (mBase[n] >> s)
                && !(s >= 8 && mAttr[n][8 + ((a >> (s - 3)) & 7)])) h = n;
        end
        if (h < 0) begin
            r.fault = 1;
            return r;
        end
        t = mAttr[h];
        r.hit = 1;
        r.execNever = t[28];
        if (t[21:19] != 3'h0) begin
            r.memType = MEM_NORMAL;
            r.shareable = t[18];
            r.cacheable = (t[21:19] != 3'h1);
            r.writeBack = r.cacheable && t[16];
        end else if (t[17]) begin
            r.memType = MEM_NORMAL; r.shareable = t[18]; r.cacheable = 1; r.writeBack = t[16];
        end else if (t[16]) begin
            r.memType = MEM_DEVICE; r.shareable = t[18]; r.bufferable = 1; r.ordered = 1;
        end else begin
            r.memType = MEM_STRONG; r.shareable = 1; r.ordered = 1;
        end
        return r;
    endfunction
    // Posting of normal writes and the attributes of a miss are left open
    function automatic mrpu_attr_type care(input mrpu_attr_type e);
        mrpu_attr_type c;
        c = '1;
        if (e.memType == MEM_NORMAL) c.bufferable = 0;
        if (e.fault) begin
            c = '0;
            c.hit = 1'b1;
            c.fault = 1'b1;
        end
        return c;
    endfunction
    task automatic run(input int cnt);
        mrpu_attr_type ed;
        mrpu_attr_type ef;
        for (int i = 0; i < cnt; i++) begin
            @(posedge ref_clk);
            dataGo <= 1'($random(seed)); fetchGo <= 1'($random(seed)); dataWr <= 1'($random(seed));
            dAddr <= $random(seed) & 32'h0000_3FFF; fAddr <= $random(seed) & 32'h0000_3FFF;
            @(posedge ref_clk);
            #1;
            ed = model(dAddr, dataGo);
            ef = model(fAddr, fetchGo);
            chk("dataAttr", 32'(ed & care(ed)), 32'(dataAttr & care(ed)));
            chk("fetchAttr", 32'(ef & care(ef)), 32'(fetchAttr & care(ef)));
            chk("fetchBlocked", 32'(fetchGo && (ef.fault || ef.execNever)), 32'(fetchBlocked));
            chk("execFault", 0, 32'(execFault));
            sawD |= ed.fault;
            sawF |= fetchGo && (ef.fault || ef.execNever);
        end
        @(posedge ref_clk);
        dataGo <= 0; fetchGo <= 0;
    endtask

    // ======
    // Main sequence
    initial begin
        for (int n = 0; n < 8; n++) begin
            mBase[n] = 0;
            mAttr[n] = 0;
        end
        repeat (6) @(posedge ref_clk);
        resetn <= 1;
        rdc(OFS_CTRL, 0, 0);
        rdc(OFS_STATUS, 0, 0);
        rdc(OFS_MASK, 0, 0);
        for (int n = 0; n < 8; n++) rdc(OFS_REGION_ATTR + 12'(8 * n), ATTR_RESET, 0);
        rdc(OFS_REGION_END, 0, 1);
        rdc(12'h006, 0, 1);
        apb(OFS_CTRL, 1'b1, 32'h0000_0001, 4'h1);
        chk("pslverr", 1, er);
        rdc(OFS_CTRL, 0, 0);
        run(20);
        // Mask stays clear and spare regions are cleared while reconfiguring
        cfg(0, 32'h0000_0000, 32'h0002_0017);
        cfg(1, 32'h0000_0000, 32'h0000_0000);
        apb(OFS_REGION_ATTR + 12'h008, 1'b1, 32'h0000_0313, 4'h1);
        apb(OFS_REGION_ATTR + 12'h008, 1'b1, 32'h0000_0313, 4'h2);
        mAttr[1] = 32'h0000_0313;
        rdc(OFS_REGION_ATTR + 12'h008, 32'h0000_0313, 0);
        cfg(2, 32'h0000_2000, 32'h1005_800F);
        cfg(3, 32'h0000_3000, 32'h0007_0009);
        cfg(4, 32'h0000_1000, 32'h0009_0015);
        cfg(5, 32'h0000_1800, 32'h0011_0015);
        for (int n = 6; n < 8; n++) cfg(n, 32'h0000_0000, 32'h0000_0000);
        apb(OFS_CTRL, 1'b1, 32'h0000_0001, 4'hF);
        mOn = 1;
        run(80);
        rdc(OFS_STATUS, 32'({sawF, sawD}), 0);
        apb(OFS_STATUS, 1'b1, 32'h0000_0007, 4'hF);
        rdc(OFS_STATUS, 0, 0);
        apb(OFS_MASK, 1'b1, 32'h0000_0004, 4'hF);
        @(posedge ref_clk);
        fAddr <= 32'h0000_2010; fetchGo <= 1;
        @(posedge ref_clk);
        fetchGo <= 0;
        #1;
        chk("fetchBlocked", 1, 32'(fetchBlocked));
        chk("execFault", 0, 32'(execFault));
        chk("irq", 0, 32'(irq));
        @(posedge ref_clk);
        execGo <= 1;
        @(posedge ref_clk);
        execGo <= 0;
        #1;
        chk("execFault", 1, 32'(execFault));
        chk("irq", 1, 32'(irq));
        rdc(OFS_FAULT_ADDR, 32'h0000_2010, 0);
        rdc(OFS_STATUS, 32'h0000_0006, 0);
        apb(OFS_STATUS, 1'b1, 32'h0000_0004, 4'hF);
        #1;
        chk("irq", 0, 32'(irq));
        end_of_test();
    end
endmodule
`default_nettype wire
